// File: dv/flash_model.sv
`timescale 1ns/1ps
// behavioural serial flash holding header, payload and checksum
module flash_model
    import cfg_loader_pkg::*;
#(
    parameter int PAYLOAD_BITS = 32
) (
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic [3:0] rate,
    input wire logic corrupt,
    output logic miso,
    output logic [31:0] cmd_word,
    output logic [7:0] cmd_count,
    output real first_per,
    output real last_per
);
    localparam int N = HDR_BITS + PAYLOAD_BITS + CRC_BITS;
    logic [N-1:0] stream; // image, msb sent first
    int bit_no; // rising edges since select
    int out_no; // bits handed out
    realtime t_rise; // time of previous rising edge
    // image rebuilt whenever the bench changes rate or error flag
    function automatic logic [N-1:0] build(input logic [3:0] r,
                                          input logic bad);
        logic [N-1:0] s;
        logic [15:0] crc;
        logic b;
        s = '0;
        crc = CRC_INIT;
        s[N-1 -: 32] = {28'h000_0000, r}; // rate field in low bits
        for (int i = 0; i < PAYLOAD_BITS; i++) begin
            b = i[0] ^ i[2];
            s[N-33-i] = b;
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
        end
        s[15:0] = crc ^ {15'h0000, bad}; // one bit flipped on demand
        return s;
    endfunction : build
    // evaluated at time zero as well, so the image is never unknown
    always_comb stream = build(rate, corrupt);
    initial begin
        miso = 1'b0;
        cmd_word = 32'h0000_0000;
        cmd_count = 8'h00;
        first_per = 0.0;
        last_per = 0.0;
        bit_no = 0;
        out_no = 0;
    end
    // new transfer only when selected low
    always @(negedge sel_n) begin
        bit_no = 0;
        out_no = 0;
    end
    // released line shows the inverse, never a stale copy
    always @(posedge sel_n) miso = ~miso;
    // command captured on rising edges, msb first
    always @(posedge sck) begin
        if (!sel_n) begin
            if (bit_no < CMD_BITS) begin
                cmd_word = {cmd_word[30:0], mosi};
            end
            if (bit_no == CMD_BITS - 1) begin
                cmd_count = cmd_count + 8'h01;
            end
            if (bit_no == 1) first_per = $realtime - t_rise;
            if (bit_no > 0) last_per = $realtime - t_rise;
            t_rise = $realtime;
            bit_no++;
        end
    end
    // data launched after falling edges, valid at the next rise
    always @(negedge sck) begin
        if (!sel_n && bit_no >= CMD_BITS && out_no < N) begin
            miso = stream[N-1-out_no];
            out_no++;
        end
    end
endmodule : flash_model

// File: dv/test_spi_flash_config_loader.sv
`timescale 1ns/1ps
module test_spi_flash_config_loader;
    import cfg_loader_pkg::*;
    localparam int CLR = 50; // short clearing time for simulation
    localparam int PB = 32;
    localparam logic [3:0] RATE = 4'h1;
    localparam int SH = int'(SLOW_HALF >> RATE);
    localparam int FAST = (SH > int'(MIN_HALF)) ? SH : int'(MIN_HALF);
    logic ref_clk, osc_clk, nrst, prog_n, hold_n, corrupt, miso;
    logic [2:0] mode, variant, mode_l, var_l;
    logic init_n_out, init_n_oe, done_out, done_oe, mosi, sck, bus_oe;
    logic sel_n, sel_oe, chain, chain_oe, init_pad, sel_w;
    logic [31:0] cmd_word;
    logic [7:0] cmd_count;
    real first_per, last_per;
    int failures, checks, cycles;
    // open-drain init with pull-up, outside party may hold it low
    assign init_pad = hold_n & ~(init_n_oe & ~init_n_out);
    assign sel_w = sel_oe ? sel_n : 1'b1; // select pulled up when free
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // oscillator clock, phase unrelated to the control clock
    initial begin
        osc_clk = 1'b0;
        #3;
        // first rise lands inside reset so the link side is cleared
        forever begin
            osc_clk = ~osc_clk;
            #32;
        end
    end
    spi_flash_config_loader #(.CLEAR_CYCLES(CLR), .PAYLOAD_BITS(PB),
        .START_ADDR(24'h00_0000)) spi_flash_config_loader_i (
        .REF_CLK(ref_clk), .NRST(nrst), .OSC_CLK(osc_clk),
        .RECONFIG_REQUEST_N(prog_n), .INIT_N_IN(init_pad),
        .INIT_N_OUT(init_n_out), .INIT_N_OE(init_n_oe),
        .DONE_OUT(done_out), .DONE_OE(done_oe), .MODE_PINS(mode),
        .READ_VARIANT_PINS(variant), .MODE_LATCHED(mode_l),
        .VARIANT_LATCHED(var_l), .FLASH_DATA_IN(miso),
        .FLASH_DATA_OUT(mosi), .CONFIG_SERIAL_CLOCK(sck),
        .FLASH_BUS_OE(bus_oe), .PROM_SELECT_N(sel_n),
        .PROM_SELECT_OE(sel_oe), .CHAIN_OUT(chain), .CHAIN_OE(chain_oe));
    flash_model #(.PAYLOAD_BITS(PB)) flash_model_i (.sck(sck),
        .sel_n(sel_w), .mosi(mosi), .rate(RATE), .corrupt(corrupt),
        .miso(miso), .cmd_word(cmd_word), .cmd_count(cmd_count),
        .first_per(first_per), .last_per(last_per));
    task automatic final_report();
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // inputs move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    // bounded wait for the select wire to reach a level
    task automatic wait_sel(input logic v);
        int i;
        i = 0;
        while (sel_w !== v && i < 20000) begin
            step(1);
            i++;
        end
        if (i >= 20000) chk(32'h0000_0000, 32'h0000_0001);
    endtask : wait_sel
    // hang guard, well above two full loads
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        nrst = 1'b0;
        prog_n = 1'b1;
        hold_n = 1'b1;
        corrupt = 1'b0;
        mode = 3'h1;
        variant = 3'h5;
        failures = 0;
        checks = 0;
        step(4);
        chk({init_n_oe, init_n_out, done_oe, sel_w, bus_oe, chain_oe},
            6'b101100);
        nrst = 1'b1;
        hold_n = 1'b0; // flash not ready yet, start delayed
        step(CLR + 20);
        chk({init_n_oe, sel_w}, 2'b01);
        hold_n = 1'b1;
        step(10);
        chk({mode_l, var_l}, {3'h1, 3'h5});
        wait_sel(1'b0);
        step(200);
        chk({sel_oe, bus_oe, chain_oe, done_oe, done_out},
            5'b11110);
        wait_sel(1'b1);
        step(20);
        chk({done_oe, init_n_oe, init_n_out, bus_oe, chain_oe},
            5'b01100);
        chk({sel_oe, sel_n}, 2'b11);
        // chain output holds the last stream bit forwarded
        chk({31'h0000_0000, chain},
            {31'h0000_0000, flash_model_i.stream[0]});
        chk(cmd_word, {READ_CMD, 24'h00_0000});
        chk({24'h00_0000, cmd_count}, 32'h0000_0001);
        chk($rtoi(first_per), 2 * int'(SLOW_HALF) * 64);
        chk($rtoi(last_per), 2 * FAST * 64);
        // pulse below the minimum width leaves the device configured
        prog_n = 1'b0;
        step(20);
        prog_n = 1'b1;
        step(10);
        // still configured: done released, init driven high
        chk({done_oe, init_n_oe, init_n_out}, 3'b011);
        // long pulse: pins float and nothing starts while low
        prog_n = 1'b0;
        // 40 cycles to qualify, then the link side needs up to 4 of its
        // own edges before the select enable drops
        step(90);
        chk({init_n_oe, done_oe, sel_oe, bus_oe, chain_oe},
            5'b00000);
        step(CLR + 20);
        chk({sel_w, init_n_oe}, 2'b10);
        corrupt = 1'b1;
        prog_n = 1'b1;
        step(6);
        chk({init_n_oe, init_n_out, done_oe}, 3'b101);
        wait_sel(1'b0);
        wait_sel(1'b1);
        step(20);
        chk({init_n_oe, init_n_out, done_oe}, 3'b101);
        chk({24'h00_0000, cmd_count}, 32'h0000_0002);
        final_report();
    end
endmodule : test_spi_flash_config_loader

// File: hw/cfg_loader_pkg.sv
package cfg_loader_pkg;
    // reference clock
    localparam int REF_PERIOD_NS = 8;
    // least program pulse, rounded up to whole cycles
    localparam int PROG_MIN_NS = 300;
    localparam int PROG_MIN_CYC = (PROG_MIN_NS + REF_PERIOD_NS - 1)
        / REF_PERIOD_NS;
    localparam logic [5:0] PROG_MIN_CNT = 6'(PROG_MIN_CYC);
    // configuration memory clearing time
    localparam int CLEAR_TIME_NS = 1_000_000;
    localparam int CLEAR_CYC = CLEAR_TIME_NS / REF_PERIOD_NS;
    // flash read command and bit counts of the stream
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam int CMD_BITS = 32;
    localparam int HDR_BITS = 32;
    localparam int CRC_BITS = 16;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    // serial clock half periods in oscillator cycles
    localparam logic [7:0] SLOW_HALF = 8'h08;
    localparam logic [7:0] MIN_HALF = 8'h02;
    // header field holding the clock rate option
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 4;
    // control side states
    typedef enum logic [2:0] {
        R_CLEAR = 3'b000,
        R_WAIT = 3'b001,
        R_LOAD = 3'b010,
        R_DONE = 3'b011,
        R_ERROR = 3'b100,
        R_HOLD = 3'b101
    } ref_state_e;
    // link side states
    typedef enum logic [2:0] {
        O_IDLE = 3'b000,
        O_CMD = 3'b001,
        O_DATA = 3'b010,
        O_END = 3'b011,
        O_FAIL = 3'b100
    } osc_state_e;
    // load result crossing back to the control side
    typedef struct packed {
        logic ok;
        logic err;
    } load_status_s;
endpackage : cfg_loader_pkg

// File: hw/spi_flash_config_loader.sv
`timescale 1ns/1ps
module spi_flash_config_loader
    import cfg_loader_pkg::*;
#(
    parameter int CLEAR_CYCLES = CLEAR_CYC,
    parameter int PAYLOAD_BITS = 1024,
    parameter logic [23:0] START_ADDR = 24'h00_0000
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic OSC_CLK,
    input wire logic RECONFIG_REQUEST_N,
    input wire logic INIT_N_IN,
    output logic INIT_N_OUT,
    output logic INIT_N_OE,
    output logic DONE_OUT,
    output logic DONE_OE,
    input wire logic [2:0] MODE_PINS,
    input wire logic [2:0] READ_VARIANT_PINS,
    output logic [2:0] MODE_LATCHED,
    output logic [2:0] VARIANT_LATCHED,
    input wire logic FLASH_DATA_IN,
    output logic FLASH_DATA_OUT,
    output logic CONFIG_SERIAL_CLOCK,
    output logic FLASH_BUS_OE,
    output logic PROM_SELECT_N,
    output logic PROM_SELECT_OE,
    output logic CHAIN_OUT,
    output logic CHAIN_OE
);
    localparam int TOTAL = HDR_BITS + PAYLOAD_BITS + CRC_BITS;
    localparam int PW = $clog2(TOTAL + 1);
    localparam int CW = $clog2(CLEAR_CYCLES + 1);
    localparam logic [PW-1:0] LAST_CMD = PW'(CMD_BITS - 1);
    localparam logic [PW-1:0] LAST_HDR = PW'(HDR_BITS - 1);
    localparam logic [PW-1:0] LAST_PAY = PW'(HDR_BITS + PAYLOAD_BITS - 1);
    localparam logic [PW-1:0] LAST_BIT = PW'(TOTAL - 1);
    localparam logic [CW-1:0] LAST_CLR = CW'(CLEAR_CYCLES - 1);

    // refuse settings the counters cannot serve
    generate
        if (PAYLOAD_BITS < 1 || CLEAR_CYCLES < 2) begin : g_chk
            $error("loader parameters out of range");
        end
    endgenerate

    // ---------------- reference clock domain ----------------
    logic prog_s1, prog_s2; // program pin synchroniser
    logic init_s1, init_s2; // init pin synchroniser
    logic [2:0] mode_s1, mode_s2; // mode pins synchroniser
    logic [2:0] var_s1, var_s2; // variant pins synchroniser
    load_status_s st_s1, st_s2; // load result from link side
    ref_state_e r_state, next_r_state;
    logic [CW-1:0] clr_cnt, next_clr_cnt; // memory clearing timer
    logic [5:0] prog_cnt, next_prog_cnt; // program low width
    logic go, next_go; // level: link side may load
    logic next_init_oe, next_init_out, next_done_oe;
    logic [2:0] next_mode, next_var;
    load_status_s status; // driven on link side

    // pin synchronisers, first stage read only by the second
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            // program idles high, so no false low right after reset
            prog_s1 <= 1'b1;
            prog_s2 <= 1'b1;
            init_s1 <= 1'b0;
            init_s2 <= 1'b0;
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
            var_s1 <= 3'h0;
            var_s2 <= 3'h0;
            st_s1 <= '0;
            st_s2 <= '0;
        end else begin
            prog_s1 <= RECONFIG_REQUEST_N;
            prog_s2 <= prog_s1;
            init_s1 <= INIT_N_IN;
            init_s2 <= init_s1;
            mode_s1 <= MODE_PINS;
            mode_s2 <= mode_s1;
            var_s1 <= READ_VARIANT_PINS;
            var_s2 <= var_s1;
            st_s1 <= status;
            st_s2 <= st_s1;
        end
    end

    // control sequence: clear, wait for init, load, finish
    always_comb begin
        next_r_state = r_state;
        next_clr_cnt = clr_cnt;
        next_go = go;
        next_init_oe = INIT_N_OE;
        next_init_out = INIT_N_OUT;
        next_done_oe = DONE_OE;
        next_mode = MODE_LATCHED;
        next_var = VARIANT_LATCHED;
        // measure how long program has been low, saturating
        if (prog_s2) begin
            next_prog_cnt = 6'h00;
        end else if (prog_cnt != PROG_MIN_CNT) begin
            next_prog_cnt = prog_cnt + 6'h01;
        end else begin
            next_prog_cnt = prog_cnt;
        end
        unique case (r_state)
            R_CLEAR: begin
                next_clr_cnt = clr_cnt + CW'(1);
                if (clr_cnt == LAST_CLR) begin
                    next_r_state = R_WAIT;
                    next_init_oe = 1'b0;
                end
            end
            R_WAIT: begin
                // an outside hold on init or program keeps us here
                if (init_s2 && prog_s2) begin
                    next_r_state = R_LOAD;
                    next_go = 1'b1;
                    next_mode = mode_s2;
                    next_var = var_s2;
                end
            end
            R_LOAD: begin
                if (st_s2.ok) begin
                    next_r_state = R_DONE;
                    next_done_oe = 1'b0;
                    next_init_oe = 1'b1;
                    next_init_out = 1'b1;
                end else if (st_s2.err) begin
                    next_r_state = R_ERROR;
                    next_init_oe = 1'b1;
                    next_init_out = 1'b0;
                end
            end
            R_DONE, R_ERROR: begin
                next_r_state = r_state; // only program leaves these
            end
            R_HOLD: begin
                // restart only once program is released
                if (prog_s2) begin
                    next_r_state = R_CLEAR;
                    next_clr_cnt = '0;
                    next_init_oe = 1'b1;
                    next_init_out = 1'b0;
                    next_done_oe = 1'b1;
                end
            end
            default: begin
                next_r_state = R_CLEAR; // unused codes restart clearing
            end
        endcase
        // a qualified program pulse wins over every state except R_HOLD
        if (prog_cnt == PROG_MIN_CNT && r_state != R_HOLD) begin
            next_r_state = R_HOLD;
            next_go = 1'b0;
            next_init_oe = 1'b0;
            next_done_oe = 1'b0;
        end
    end

    // control registers; power-on starts with memory clearing
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            r_state <= R_CLEAR;
            clr_cnt <= '0;
            prog_cnt <= 6'h00;
            go <= 1'b0;
            INIT_N_OE <= 1'b1;
            INIT_N_OUT <= 1'b0;
            DONE_OE <= 1'b1;
            DONE_OUT <= 1'b0;
            MODE_LATCHED <= 3'h0;
            VARIANT_LATCHED <= 3'h0;
        end else begin
            r_state <= next_r_state;
            clr_cnt <= next_clr_cnt;
            prog_cnt <= next_prog_cnt;
            go <= next_go;
            INIT_N_OE <= next_init_oe;
            INIT_N_OUT <= next_init_out;
            DONE_OE <= next_done_oe;
            DONE_OUT <= 1'b0;
            MODE_LATCHED <= next_mode;
            VARIANT_LATCHED <= next_var;
        end
    end

    // ---------------- oscillator (link) domain ----------------
    logic orst_s1, orst_n; // local reset release synchroniser
    logic go_s1, go_s2; // load permission synchroniser
    logic miso_s1, miso_s2; // flash data synchroniser
    osc_state_e o_state, next_o_state;
    logic [7:0] cnt, next_cnt, half, next_half; // clock divider
    logic [31:0] sreg, next_sreg; // command / header shifter
    logic [PW-1:0] pos, next_pos; // bit index in phase
    logic [15:0] crc, next_crc; // running checksum
    logic next_sck, next_mosi, next_sel_n, next_sel_oe;
    logic next_bus_oe, next_chain, next_chain_oe;
    load_status_s next_status;

    // slow clock picked by the header rate field, never below min
    function automatic logic [7:0] rate_half(input logic [RATE_W-1:0] r);
        logic [7:0] h;
        h = SLOW_HALF >> r;
        rate_half = (h < MIN_HALF) ? MIN_HALF : h;
    endfunction : rate_half

    always_ff @(posedge OSC_CLK or negedge NRST) begin
        if (!NRST) begin
            orst_s1 <= 1'b0;
            orst_n <= 1'b0;
            go_s1 <= 1'b0;
            go_s2 <= 1'b0;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            orst_s1 <= 1'b1;
            orst_n <= orst_s1;
            go_s1 <= go;
            go_s2 <= go_s1;
            miso_s1 <= FLASH_DATA_IN;
            miso_s2 <= miso_s1;
        end
    end

    // serial engine: command out, stream in, checksum check
    always_comb begin
        logic edge_now, bit_in;
        edge_now = (cnt == half - 8'h01);
        bit_in = miso_s2;
        next_o_state = o_state;
        next_cnt = cnt;
        next_half = half;
        next_sreg = sreg;
        next_pos = pos;
        next_crc = crc;
        next_sck = CONFIG_SERIAL_CLOCK;
        next_mosi = FLASH_DATA_OUT;
        next_sel_n = PROM_SELECT_N;
        next_sel_oe = PROM_SELECT_OE;
        next_bus_oe = FLASH_BUS_OE;
        next_chain = CHAIN_OUT;
        next_chain_oe = CHAIN_OE;
        next_status = status;
        unique case (o_state)
            O_IDLE: begin
                // pins float until a load is permitted
                next_sel_oe = 1'b0;
                next_bus_oe = 1'b0;
                next_chain_oe = 1'b0;
                next_sel_n = 1'b1;
                next_sck = 1'b0;
                next_status = '0;
                if (go_s2) begin
                    next_o_state = O_CMD;
                    next_sel_n = 1'b0;
                    next_sel_oe = 1'b1;
                    next_bus_oe = 1'b1;
                    next_chain_oe = 1'b1;
                    next_sreg = {READ_CMD[6:0], START_ADDR, 1'b0};
                    next_mosi = READ_CMD[7];
                    next_pos = '0;
                    next_cnt = 8'h00;
                    next_half = SLOW_HALF;
                    next_crc = CRC_INIT;
                end
            end
            O_CMD, O_DATA: begin
                if (!edge_now) begin
                    next_cnt = cnt + 8'h01;
                end else begin
                    next_cnt = 8'h00;
                    next_sck = ~CONFIG_SERIAL_CLOCK;
                end
                if (edge_now && CONFIG_SERIAL_CLOCK && o_state == O_CMD) begin
                    // falling edge: present the next command bit
                    next_mosi = sreg[31];
                    next_sreg = {sreg[30:0], 1'b0};
                    next_pos = pos + PW'(1);
                    if (pos == LAST_CMD) begin
                        next_o_state = O_DATA;
                        next_pos = '0;
                    end
                end else if (edge_now && CONFIG_SERIAL_CLOCK) begin
                    // bit held through the high phase, taken now
                    next_chain = bit_in;
                    next_pos = pos + PW'(1);
                    if (pos <= LAST_HDR || pos > LAST_PAY) begin
                        next_sreg = {sreg[30:0], bit_in};
                    end else begin
                        next_crc = {crc[14:0], 1'b0}
                            ^ ((crc[15] ^ bit_in) ? CRC_POLY : 16'h0000);
                    end
                    if (pos == LAST_HDR) begin
                        next_half = rate_half(
                            {sreg[RATE_LSB+RATE_W-2:RATE_LSB], bit_in});
                    end
                    if (pos == LAST_BIT) begin
                        next_sel_n = 1'b1;
                        next_bus_oe = 1'b0;
                        next_chain_oe = 1'b0;
                        next_sck = 1'b0;
                        if ({sreg[14:0], bit_in} == crc) begin
                            next_o_state = O_END;
                        end else begin
                            next_o_state = O_FAIL;
                        end
                    end
                end
                if (!go_s2) begin
                    next_o_state = O_IDLE; // abort on program
                end
            end
            O_END, O_FAIL: begin
                // no retry: one read per attempt
                next_status.ok = (o_state == O_END);
                next_status.err = (o_state == O_FAIL);
                if (!go_s2) begin
                    next_o_state = O_IDLE;
                end
            end
            default: begin
                next_o_state = O_IDLE;
            end
        endcase
    end

    // link registers; everything off until reset is released
    always_ff @(posedge OSC_CLK or negedge NRST) begin
        if (!NRST) begin
            o_state <= O_IDLE;
            cnt <= 8'h00;
            half <= SLOW_HALF;
            sreg <= 32'h0000_0000;
            pos <= '0;
            crc <= CRC_INIT;
            CONFIG_SERIAL_CLOCK <= 1'b0;
            FLASH_DATA_OUT <= 1'b0;
            PROM_SELECT_N <= 1'b1;
            PROM_SELECT_OE <= 1'b0;
            FLASH_BUS_OE <= 1'b0;
            CHAIN_OUT <= 1'b0;
            CHAIN_OE <= 1'b0;
            status <= '0;
        end else if (!orst_n) begin
            o_state <= O_IDLE;
        end else begin
            o_state <= next_o_state;
            cnt <= next_cnt;
            half <= next_half;
            sreg <= next_sreg;
            pos <= next_pos;
            crc <= next_crc;
            CONFIG_SERIAL_CLOCK <= next_sck;
            FLASH_DATA_OUT <= next_mosi;
            PROM_SELECT_N <= next_sel_n;
            PROM_SELECT_OE <= next_sel_oe;
            FLASH_BUS_OE <= next_bus_oe;
            CHAIN_OUT <= next_chain;
            CHAIN_OE <= next_chain_oe;
            status <= next_status;
        end
    end

    // ---------------- checks ----------------
    sequence s_release;
        (r_state == R_HOLD) && prog_s2;
    endsequence
    sequence s_cleared;
        (r_state == R_CLEAR) && INIT_N_OE && !INIT_N_OUT && DONE_OE;
    endsequence
    AST_INIT_CLEAR: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        r_state == R_CLEAR |-> INIT_N_OE && !INIT_N_OUT)
        else $error("init not low while clearing");
    AST_MODE_SAMPLE: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        $rose(go) |-> MODE_LATCHED == $past(mode_s2) && !INIT_N_OE)
        else $error("mode pins not sampled at init release");
    AST_WAIT_HOLD: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        r_state == R_WAIT && !init_s2 |=> !go)
        else $error("loading began while init held low");
    AST_PROG_START: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        $rose(go) |-> $past(prog_s2, 1))
        else $error("loading began while program low");
    AST_PROG_HOLD: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        prog_cnt == PROG_MIN_CNT && r_state != R_HOLD |=>
        r_state == R_HOLD && !go ##1 !INIT_N_OE && !DONE_OE)
        else $error("program pulse did not restart");
    AST_RESTART: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        s_release |=> s_cleared)
        else $error("no clearing after program release");
    AST_DONE_LOW: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        r_state inside {R_CLEAR, R_WAIT, R_LOAD} |-> DONE_OE)
        else $error("done released before success");
    AST_CRC_INIT: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        r_state == R_LOAD && st_s2.err && prog_cnt != PROG_MIN_CNT |=>
        INIT_N_OE && !INIT_N_OUT)
        else $error("checksum error did not pull init low");
    AST_SEL_LOW: assert property (@(posedge OSC_CLK)
        disable iff (!NRST)
        o_state inside {O_CMD, O_DATA} |-> !PROM_SELECT_N && PROM_SELECT_OE)
        else $error("flash not selected while reading");
    AST_MOSI_FALL: assert property (@(posedge OSC_CLK)
        disable iff (!NRST)
        o_state == O_CMD && $past(o_state) == O_CMD && $changed(FLASH_DATA_OUT)
        |-> $fell(CONFIG_SERIAL_CLOCK))
        else $error("command bit changed off the falling edge");
    AST_SLOW_START: assert property (@(posedge OSC_CLK)
        disable iff (!NRST)
        o_state == O_CMD |-> half == SLOW_HALF)
        else $error("command not sent at slowest clock");
    AST_DESELECT: assert property (@(posedge OSC_CLK)
        disable iff (!NRST)
        o_state == O_END |-> PROM_SELECT_N && PROM_SELECT_OE && !FLASH_BUS_OE)
        else $error("flash not deselected after loading");
endmodule : spi_flash_config_loader
